// file: pkg/core_pkg.sv
// Purpose: shared constants and types of the 14-bit instruction core
// Assumes: 32-bit apb, byte addressed, one word per register
// Notes:   file and bus maps are fixed here, nowhere else
package core_pkg;
  localparam int WORD_W  = 14;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W    = 13;
  localparam int JUMP_W  = 11;
  localparam int PHASES  = 4;   // oscillator periods per cycle
  localparam int STACK_D = 8;
  localparam int FILE_D  = 128;
  // apb register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ACC  = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_PC   = 8'h0c;
  // control and status bit positions
  localparam int B_RUN = 0;
  localparam int B_PSA = 1;
  localparam int B_C   = 0;
  localparam int B_DC  = 1;
  localparam int B_Z   = 2;
  localparam int B_PD  = 3;
  localparam int B_TO  = 4;
  // special file addresses
  localparam logic [6:0] F_TIMER_ZERO_COUNT = 7'h01;
  localparam logic [6:0] F_STAT = 7'h03;
  localparam logic [6:0] F_PORT = 7'h05;
  // instruction field positions
  localparam int D_POS   = 7;
  localparam int CLS_LO  = 12;
  localparam int OP_LO   = 8;
  localparam int BS_LO   = 7;
  localparam int BSUB_LO = 10;
  localparam int J_SEL   = 11;
  // instruction classes
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_JMP  = 2'h2;
  // byte opcodes
  localparam logic [3:0] OP_MOVW = 4'h0;
  localparam logic [3:0] OP_CLR  = 4'h1;
  localparam logic [3:0] OP_SUB  = 4'h2;
  localparam logic [3:0] OP_DEC  = 4'h3;
  localparam logic [3:0] OP_IOR  = 4'h4;
  localparam logic [3:0] OP_AND  = 4'h5;
  localparam logic [3:0] OP_XOR  = 4'h6;
  localparam logic [3:0] OP_ADD  = 4'h7;
  localparam logic [3:0] OP_MOV  = 4'h8;
  localparam logic [3:0] OP_COM  = 4'h9;
  localparam logic [3:0] OP_INC  = 4'ha;
  localparam logic [3:0] OP_DECS = 4'hb;
  localparam logic [3:0] OP_RR   = 4'hc;
  localparam logic [3:0] OP_RL   = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCS = 4'hf;
  // literal opcodes
  localparam logic [3:0] L_OR  = 4'h8;
  localparam logic [3:0] L_AND = 4'h9;
  localparam logic [3:0] L_XOR = 4'ha;
  // fixed control words, low byte with upper bits zero
  localparam logic [7:0] W_RET   = 8'h08;
  localparam logic [7:0] W_RETI  = 8'h09;
  localparam logic [7:0] W_SLEEP = 8'h63;
  localparam logic [7:0] W_WDT   = 8'h64;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PA, ALU_PB,
    ALU_COM, ALU_INC, ALU_DEC, ALU_RL, ALU_RR, ALU_SWAP, ALU_CLR
  } alu_op_type;
  typedef enum logic [2:0] {
    ST_HALT  = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } core_state_type;
endpackage : core_pkg

// file: pkg/alu_if.sv
// Purpose: operand and result bundle between core and alu
// Assumes: purely combinational alu
// Notes:   a is file or literal, b is the accumulator
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
  core_pkg::alu_op_type op;
  logic [7:0]           a;
  logic [7:0]           b;
  logic                 cin;
  logic [7:0]           y;
  logic                 cout;
  logic                 dcout;
  logic                 zero;
  modport core (output op, a, b, cin, input y, cout, dcout, zero);
  modport alu  (input op, a, b, cin, output y, cout, dcout, zero);
endinterface : alu_if
`default_nettype wire

// file: src/exec_alu.sv
// Purpose: eight-bit arithmetic and logic unit of the core
// Assumes: subtract means a minus b, carry set when no borrow
// Notes:   digit carry always comes from the adder
`timescale 1ns/100ps
`default_nettype none
module exec_alu (
  alu_if.alu u
);
  logic       sub;
  logic [7:0] bx;
  logic [8:0] sum;
  logic [4:0] nib;
  // subtract as a plus inverted b plus one
  assign sub = (u.op == core_pkg::ALU_SUB);
  assign bx  = sub ? ~u.b : u.b;
  assign sum = {1'h0, u.a} + {1'h0, bx} + {8'h00, sub};
  assign nib = {1'h0, u.a[3:0]} + {1'h0, bx[3:0]} + {4'h0, sub};
  // result and carry selection
  always_comb begin
    u.y    = sum[7:0];
    u.cout = u.cin;
    case (u.op)
      core_pkg::ALU_ADD,
      core_pkg::ALU_SUB:  u.cout = sum[8];
      core_pkg::ALU_AND:  u.y = u.a & u.b;
      core_pkg::ALU_OR:   u.y = u.a | u.b;
      core_pkg::ALU_XOR:  u.y = u.a ^ u.b;
      core_pkg::ALU_PA:   u.y = u.a;
      core_pkg::ALU_PB:   u.y = u.b;
      core_pkg::ALU_COM:  u.y = ~u.a;
      core_pkg::ALU_INC:  u.y = u.a + 8'h01;
      core_pkg::ALU_DEC:  u.y = u.a - 8'h01;
      core_pkg::ALU_RL: begin
        u.y    = {u.a[6:0], u.cin};
        u.cout = u.a[7];
      end
      core_pkg::ALU_RR: begin
        u.y    = {u.cin, u.a[7:1]};
        u.cout = u.a[0];
      end
      core_pkg::ALU_SWAP: u.y = {u.a[3:0], u.a[7:4]};
      core_pkg::ALU_CLR:  u.y = 8'h00;
      default:            u.y = sum[7:0];
    endcase
  end
  assign u.dcout = nib[4];
  assign u.zero  = (u.y == 8'h00);
endmodule : exec_alu
`default_nettype wire

// file: src/core_top.sv
// Purpose: 14-bit word instruction decoder and executor with apb
// Assumes: program memory answers pm_word for pm_addr combinationally
// Notes:   one instruction cycle is four pclk periods
// How it works
// - file operands are always read before modify and store.
// - destination bit low writes accumulator, high writes file.
// - file field is seven bits, 0x00 to 0x7f.
// - three-bit field picks one bit of an eight-bit file.
// - don't-care bits never change the decoded operation.
// - rotate left and right through carry, only carry changes.
// - skipping decrement and increment skip next on zero, no flags.
// - or, xor, and of accumulator with file update only zero.
// - bit test skips next instruction when bit is clear.
// - bit test skips next instruction when bit is set.
// - add and subtract literal update carry, digit carry, zero.
// - or, xor, and literal with accumulator update only zero.
// - load literal, or load literal and return in two cycles.
// - standby and watchdog clear words update timeout, powerdown.
// - pc change or true test costs a second cycle as bubble.
// - port file reads take the pin levels, not the latch.
// - file write to timer zero clears prescaler when assigned.
// - instruction cycle is four clocks, one or two per instruction.
// - literals are eight bits, jump targets eleven bits.
`timescale 1ns/100ps
`default_nettype none
module core_top #(
  parameter int STACK_D = core_pkg::STACK_D
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [12:0] pm_addr,
  input  wire logic [13:0] pm_word,
  input  wire logic [7:0]  port_pins,
  output var  logic [7:0]  port_latch,
  output var  logic        prescaler_clear,
  output var  logic        watchdog_clear,
  output var  logic        standby
);
  localparam int SP_W = $clog2(STACK_D);

  core_pkg::core_state_type state_r, state_nxt;
  logic [1:0]  q_r;
  logic        tick, exec, bub_step;
  logic        bubble_r, bubble_inc_r;
  logic [12:0] pc_r, pc_nxt, pc_inc;
  logic [7:0]  acc_r, acc_nxt;
  logic        c_r, dc_r, z_r, to_r, pd_r;
  logic        c_nxt, dc_nxt, z_nxt;
  logic [1:0]  ctrl_r;
  logic [7:0]  timer_zero_count_r;
  logic [7:0]  ram [core_pkg::FILE_D];
  logic [12:0] stk [STACK_D];
  logic [SP_W-1:0] sp_r, sp_dec;

  // instruction fields
  logic [1:0]  cls, bsub;
  logic [3:0]  bop;
  logic        dbit;
  logic [6:0]  faddr;
  logic [2:0]  bsel;
  logic [7:0]  lit, fval, bmask, bres, fres;
  logic [10:0] jaddr;
  // decode results
  core_pkg::alu_op_type op;
  logic use_lit, wr_f, wr_w, up_c, up_dc, up_z;
  logic sk_zero, sk_bit, jmp, call, ret, slp, wdt, bitw;
  logic skip_take, f_is_ram, f_wr_ram, tmr_hit;
  // bus decode
  logic apb_done, bus_wr, hit_ctrl, hit_acc, hit_stat, hit_pc;
  logic mapped;
  logic [31:0] rd_mux;

  alu_if u_if ();

  exec_alu u_alu (
    .u (u_if.alu)
  );

  // instruction cycle strobe, every fourth clock
  assign tick     = (q_r == 2'(core_pkg::PHASES - 1));
  assign exec     = tick && (state_r == core_pkg::ST_RUN) && !bubble_r;
  assign bub_step = tick && (state_r == core_pkg::ST_RUN) && bubble_r;

  // field extraction
  assign cls   = pm_word[core_pkg::CLS_LO +: 2];
  assign bop   = pm_word[core_pkg::OP_LO +: 4];
  assign dbit  = pm_word[core_pkg::D_POS];
  assign faddr = pm_word[core_pkg::FADDR_W-1:0];
  assign bsel  = pm_word[core_pkg::BS_LO +: 3];
  assign bsub  = pm_word[core_pkg::BSUB_LO +: 2];
  assign lit   = pm_word[core_pkg::DATA_W-1:0];
  assign jaddr = pm_word[core_pkg::JUMP_W-1:0];

  // file read, pins stand in for the port latch
  assign f_is_ram = (faddr != core_pkg::F_TIMER_ZERO_COUNT) &&
                    (faddr != core_pkg::F_STAT) &&
                    (faddr != core_pkg::F_PORT);
  assign fval = (faddr == core_pkg::F_TIMER_ZERO_COUNT) ? timer_zero_count_r :
                (faddr == core_pkg::F_PORT) ? port_pins :
                (faddr == core_pkg::F_STAT) ?
                  {3'h0, to_r, pd_r, z_r, dc_r, c_r} :
                ram[faddr];

  // bit operations on the value just read
  assign bmask = 8'h01 << bsel;
  assign bres  = bsub[0] ? (fval | bmask) : (fval & ~bmask);
  assign fres  = bitw ? bres : u_if.y;

  // alu operands
  assign u_if.op  = op;
  assign u_if.a   = use_lit ? lit : fval;
  assign u_if.b   = acc_r;
  assign u_if.cin = c_r;

  // instruction decode; unlisted bit patterns are ignored
  always_comb begin
    op = core_pkg::ALU_PA; use_lit = 1'h0; wr_f = 1'h0; wr_w = 1'h0;
    up_c = 1'h0; up_dc = 1'h0; up_z = 1'h0; sk_zero = 1'h0;
    sk_bit = 1'h0; jmp = 1'h0; call = 1'h0; ret = 1'h0;
    slp = 1'h0; wdt = 1'h0; bitw = 1'h0;
    case (cls)
      core_pkg::CLS_BYTE: begin
        wr_f = dbit;
        wr_w = !dbit;
        up_z = 1'h1;
        case (bop)
          core_pkg::OP_MOVW: begin
            up_z = 1'h0;
            wr_w = 1'h0;
            op   = core_pkg::ALU_PB;
            ret  = !dbit && (pm_word[7:0] == core_pkg::W_RET ||
                             pm_word[7:0] == core_pkg::W_RETI);
            slp  = !dbit && (pm_word[7:0] == core_pkg::W_SLEEP);
            wdt  = !dbit && (pm_word[7:0] == core_pkg::W_WDT);
          end
          core_pkg::OP_CLR:  op = core_pkg::ALU_CLR;
          core_pkg::OP_SUB: begin
            op = core_pkg::ALU_SUB;
            up_c = 1'h1;
            up_dc = 1'h1;
          end
          core_pkg::OP_ADD: begin
            op = core_pkg::ALU_ADD;
            up_c = 1'h1;
            up_dc = 1'h1;
          end
          core_pkg::OP_DEC:  op = core_pkg::ALU_DEC;
          core_pkg::OP_INC:  op = core_pkg::ALU_INC;
          core_pkg::OP_IOR:  op = core_pkg::ALU_OR;
          core_pkg::OP_AND:  op = core_pkg::ALU_AND;
          core_pkg::OP_XOR:  op = core_pkg::ALU_XOR;
          core_pkg::OP_MOV:  op = core_pkg::ALU_PA;
          core_pkg::OP_COM:  op = core_pkg::ALU_COM;
          core_pkg::OP_DECS, core_pkg::OP_INCS: begin
            op = (bop == core_pkg::OP_DECS) ? core_pkg::ALU_DEC :
                                              core_pkg::ALU_INC;
            up_z = 1'h0;
            sk_zero = 1'h1;
          end
          core_pkg::OP_RR, core_pkg::OP_RL: begin
            op = (bop == core_pkg::OP_RL) ? core_pkg::ALU_RL :
                                            core_pkg::ALU_RR;
            up_z = 1'h0;
            up_c = 1'h1;
          end
          core_pkg::OP_SWAP: begin
            op = core_pkg::ALU_SWAP;
            up_z = 1'h0;
          end
          default: up_z = 1'h0;
        endcase
      end
      core_pkg::CLS_BIT: begin
        bitw   = !bsub[1];
        wr_f   = !bsub[1];
        sk_bit = bsub[1];
      end
      core_pkg::CLS_JMP: begin
        jmp  = pm_word[core_pkg::J_SEL];
        call = !pm_word[core_pkg::J_SEL];
      end
      default: begin
        use_lit = 1'h1;
        wr_w = 1'h1;
        up_z = 1'h1;
        case (bop[3:2])
          2'h0: up_z = 1'h0;
          2'h1: begin
            up_z = 1'h0;
            ret  = 1'h1;
          end
          2'h3: begin
            op = bop[1] ? core_pkg::ALU_ADD :
                          core_pkg::ALU_SUB;
            up_c = 1'h1;
            up_dc = 1'h1;
          end
          default: begin
            case (bop)
              core_pkg::L_OR:  op = core_pkg::ALU_OR;
              core_pkg::L_AND: op = core_pkg::ALU_AND;
              core_pkg::L_XOR: op = core_pkg::ALU_XOR;
              default: begin
                wr_w = 1'h0;
                up_z = 1'h0;
              end
            endcase
          end
        endcase
      end
    endcase
  end

  // skip decisions and write targets
  assign skip_take = (sk_zero && u_if.zero) ||
                     (sk_bit && (fval[bsel] == bsub[0]));
  assign f_wr_ram = exec && wr_f && f_is_ram;
  assign tmr_hit  = exec && wr_f && (faddr == core_pkg::F_TIMER_ZERO_COUNT);
  assign pc_inc   = pc_r + 13'h0001;
  assign sp_dec   = sp_r - SP_W'(1);

  // next program counter, bubble cycles hold or step it
  assign pc_nxt = bub_step ? (bubble_inc_r ? pc_inc : pc_r) :
                  !exec ? pc_r :
                  (jmp || call) ? {pc_r[12:11], jaddr} :
                  ret ? stk[sp_dec] :
                  pc_inc;

  // bus decode, zero wait answer
  assign apb_done = psel && penable && pready;
  assign bus_wr   = apb_done && pwrite;
  assign hit_ctrl = (paddr == core_pkg::A_CTRL);
  assign hit_acc  = (paddr == core_pkg::A_ACC);
  assign hit_stat = (paddr == core_pkg::A_STAT);
  assign hit_pc   = (paddr == core_pkg::A_PC);
  assign mapped   = hit_ctrl || hit_acc || hit_stat || hit_pc;
  assign rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
                  hit_acc  ? {24'h0, acc_r} :
                  hit_stat ? {27'h0, to_r, pd_r, z_r, dc_r, c_r} :
                  hit_pc   ? {19'h0, pc_r} : 32'h0;

  // accumulator: bus write wins over the executing instruction
  assign acc_nxt = (bus_wr && hit_acc) ? pwdata[7:0] :
                   (exec && wr_w) ? u_if.y : acc_r;

  // arithmetic flags: flag updates win over a status file write
  assign c_nxt  = (exec && up_c) ? u_if.cout :
                  (exec && wr_f && faddr == core_pkg::F_STAT) ?
                    fres[core_pkg::B_C] : c_r;
  assign dc_nxt = (exec && up_dc) ? u_if.dcout :
                  (exec && wr_f && faddr == core_pkg::F_STAT) ?
                    fres[core_pkg::B_DC] : dc_r;
  assign z_nxt  = (exec && up_z) ? u_if.zero :
                  (exec && wr_f && faddr == core_pkg::F_STAT) ?
                    fres[core_pkg::B_Z] : z_r;

  // run state follows control writes and standby entry
  assign state_nxt =
    (bus_wr && hit_ctrl) ?
      (pwdata[core_pkg::B_RUN] ? core_pkg::ST_RUN : core_pkg::ST_HALT) :
    (exec && slp) ? core_pkg::ST_SLEEP : state_r;

  // phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q_r <= 2'h0;
    else          q_r <= q_r + 2'h1;
  end

  // sequencing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= core_pkg::ST_HALT;
      pc_r         <= 13'h0000;
      bubble_r     <= 1'h0;
      bubble_inc_r <= 1'h0;
      sp_r         <= '0;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      if (bub_step) bubble_r <= 1'h0;
      else if (exec) begin
        bubble_r     <= jmp || call || ret || skip_take;
        bubble_inc_r <= skip_take;
      end
      if (exec && call)     sp_r <= sp_r + SP_W'(1);
      else if (exec && ret) sp_r <= sp_dec;
    end
  end

  // return stack, circular on overflow
  always_ff @(posedge pclk) begin
    if (exec && call) stk[sp_r] <= pc_inc;
  end

  // general purpose file memory
  always_ff @(posedge pclk) begin
    if (f_wr_ram) ram[faddr] <= fres;
  end

  // datapath registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= 8'h00;
      c_r    <= 1'h0;
      dc_r   <= 1'h0;
      z_r    <= 1'h0;
      timer_zero_count_r <= 8'h00;
      port_latch <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      c_r   <= c_nxt;
      dc_r  <= dc_nxt;
      z_r   <= z_nxt;
      if (tmr_hit) timer_zero_count_r <= fres;
      if (exec && wr_f && faddr == core_pkg::F_PORT)
        port_latch <= fres;
    end
  end

  // timeout and powerdown status, side pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_r <= 1'h1;
      pd_r <= 1'h1;
      standby <= 1'h0;
      watchdog_clear <= 1'h0;
      prescaler_clear <= 1'h0;
    end else begin
      if (exec && (slp || wdt)) begin
        to_r <= 1'h1;
        pd_r <= wdt;
      end
      standby <= (state_nxt == core_pkg::ST_SLEEP);
      watchdog_clear <= exec && (slp || wdt);
      prescaler_clear <= tmr_hit && ctrl_r[core_pkg::B_PSA];
    end
  end

  // apb slave registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= 2'h0;
      pready  <= 1'h0;
      prdata  <= 32'h0;
      pslverr <= 1'h0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !mapped;
      end
      if (bus_wr && hit_ctrl) ctrl_r <= pwdata[1:0];
    end
  end

  assign pm_addr = pc_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cycle_len: assert property (
    tick |=> !tick [*3] ##1 tick)
    else $error("instruction cycle is not four clocks");
  a_acc_dest: assert property (
    exec && cls == core_pkg::CLS_BYTE && bop == core_pkg::OP_ADD && !dbit
    && !(bus_wr && hit_acc) |=> acc_r == $past(u_if.y))
    else $error("byte result did not reach accumulator");
  a_skip_bub: assert property (
    exec && skip_take |=> bubble_r && pc_r == $past(pc_inc)
    ##4 !bubble_r && pc_r == $past(pc_r, 4) + 13'h0001)
    else $error("skip did not discard next word");
  a_jump_pc: assert property (
    exec && jmp |=> bubble_r && pc_r[10:0] == $past(jaddr)
    ##4 pc_r == $past(pc_r, 4))
    else $error("jump target or bubble wrong");
  a_bit_clear: assert property (
    exec && cls == core_pkg::CLS_BIT && bsub == 2'h0 && f_is_ram
    |=> ram[$past(faddr)][$past(bsel)] == 1'h0 && z_r == $past(z_r))
    else $error("bit clear failed or touched flags");
  a_tmr_presc: assert property (
    tmr_hit && ctrl_r[core_pkg::B_PSA] |=> prescaler_clear ##1
    !prescaler_clear)
    else $error("prescaler not cleared on timer write");
  a_sleep_flags: assert property (
    exec && slp |=> to_r && !pd_r && standby && watchdog_clear)
    else $error("standby entry status wrong");
  a_zero_only: assert property (
    exec && use_lit && bop == core_pkg::L_OR
    |=> z_r == $past(u_if.zero) && c_r == $past(c_r)
        && dc_r == $past(dc_r))
    else $error("logic literal flags wrong");
  a_dsz_flags: assert property (
    exec && sk_zero && !(wr_f && faddr == core_pkg::F_STAT)
    |=> z_r == $past(z_r))
    else $error("skip on zero changed zero flag");

  c_skip:  cover property (exec && skip_take);
  c_call:  cover property (exec && call ##[1:40] exec && ret);
  c_sleep: cover property (exec && slp);
  c_err:   cover property (apb_done && pslverr);
endmodule : core_top
`default_nettype wire

// file: sim/prog_mem.sv
// Purpose: program memory model feeding instruction words to the core
// Assumes: word answers the current address combinationally
// Notes:   sixteen words, upper address bits ignored, loaded by the bench
`timescale 1ns/100ps
`default_nettype none
module prog_mem (
  input  wire logic [12:0] pm_addr,
  output var  logic [13:0] pm_word
);
  logic [13:0] mem [0:15];
  // word lookup for the address the core presents
  assign pm_word = mem[pm_addr[3:0]];
endmodule : prog_mem
`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench of the instruction core over apb
// Assumes: pready answers one cycle after setup
// Notes:   two short programs around a mid-run reset, registers and pins
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  port_pins = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [12:0] pm_addr;
  logic [13:0] pm_word;
  logic [7:0]  port_latch;
  logic        prescaler_clear;
  logic        watchdog_clear;
  logic        standby;
  logic [7:0]  v;
  logic [32:0] exp_q [$];
  logic [32:0] e;
  logic [31:0] rnd;
  int          seed = 32'h6413;
  int          err_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          presc_pulses = 0;
  int          wdc_pulses = 0;
  int          n;
  always #50 pclk = ~pclk;
  core_top u_core_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_addr(pm_addr), .pm_word(pm_word), .port_pins(port_pins),
    .port_latch(port_latch), .prescaler_clear(prescaler_clear),
    .watchdog_clear(watchdog_clear), .standby(standby));
  prog_mem u_prog_mem (.pm_addr(pm_addr), .pm_word(pm_word));
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task cmp(input string what, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, x, g);
    end
  endtask : cmp
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] x, input logic se);
    exp_q.push_back({se, x});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // watcher takes the oldest note whenever read data is handed back
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      cmp("prdata", e[31:0], prdata);
      cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    end
  end
  // hang guard and side pulse counters
  always @(posedge pclk) begin
    cycles++;
    if (prescaler_clear === 1'b1) presc_pulses++;
    if (watchdog_clear === 1'b1) wdc_pulses++;
    if (cycles == 5000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    u_prog_mem.mem[0] = 14'h303c;  // load 0x3c
    u_prog_mem.mem[1] = 14'h00a0;  // store acc to file 0x20
    u_prog_mem.mem[2] = 14'h3803;  // or literal, acc 0x3f
    u_prog_mem.mem[3] = 14'h0620;  // xor file into acc, 0x03
    u_prog_mem.mem[4] = 14'h1820;  // bit 0 of 0x3c clear, skip
    u_prog_mem.mem[5] = 14'h30ff;  // discarded word
    u_prog_mem.mem[6] = 14'h3ffd;  // add literal, loose bit set
    u_prog_mem.mem[7] = 14'h2807;  // jump to itself
    for (n = 8; n < 16; n++) u_prog_mem.mem[n] = 14'h0000;
    repeat (16) @(posedge pclk);
    rnd = $random(seed);
    presetn <= 1'b1;
    port_pins <= rnd[15:8];
    apb(1'b1, core_pkg::A_ACC, {24'h0, rnd[7:0]});
    rd(core_pkg::A_ACC, {24'h0, rnd[7:0]}, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    rd(core_pkg::A_STAT, 32'h18, 1'b0);
    apb(1'b1, core_pkg::A_CTRL, 32'h1);
    n = 0;
    while (pm_addr !== 13'h7 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (16) @(posedge pclk);
    apb(1'b1, core_pkg::A_CTRL, 32'h0);
    rd(core_pkg::A_ACC, 32'h0, 1'b0);  // skip honoured
    rd(core_pkg::A_STAT, 32'h1f, 1'b0);  // carry, half, zero set
    rd(core_pkg::A_PC, 32'h7, 1'b0);  // jump target held
    // mid-run reset, then a second program: stack, rotate, port, timer
    @(posedge pclk);
    presetn <= 1'b0;
    u_prog_mem.mem[0]  = 14'h3081;  // load 0x81
    u_prog_mem.mem[1]  = 14'h00a1;  // store acc to file 0x21
    u_prog_mem.mem[2]  = 14'h0da1;  // rotate left, file 0x02, carry 1
    u_prog_mem.mem[3]  = 14'h10a1;  // clear bit 1, file 0x00
    u_prog_mem.mem[4]  = 14'h0fa1;  // increment to 1, no skip
    u_prog_mem.mem[5]  = 14'h0ba1;  // decrement to 0, skip
    u_prog_mem.mem[6]  = 14'h30ee;  // discarded word
    u_prog_mem.mem[7]  = 14'h200f;  // call 15
    u_prog_mem.mem[8]  = 14'h0721;  // add file 0x21 into acc
    u_prog_mem.mem[9]  = 14'h0605;  // xor port pins into acc
    u_prog_mem.mem[10] = 14'h0085;  // store acc to port
    u_prog_mem.mem[11] = 14'h0081;  // store acc to timer zero
    u_prog_mem.mem[12] = 14'h0063;  // standby entry
    for (n = 13; n < 15; n++) u_prog_mem.mem[n] = 14'h0000;
    u_prog_mem.mem[15] = 14'h345a;  // return with 0x5a
    repeat (3) @(posedge pclk);
    rnd = $random(seed);
    presetn <= 1'b1;
    port_pins <= rnd[15:8];
    v = 8'h5a ^ rnd[15:8];
    cmp("standby", 32'h0, {31'h0, standby});
    rd(core_pkg::A_STAT, 32'h18, 1'b0);  // status after reset
    rd(core_pkg::A_ACC, 32'h0, 1'b0);  // acc cleared by reset
    apb(1'b1, core_pkg::A_CTRL, 32'h3);
    n = 0;
    while (pm_addr !== 13'hd && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (8) @(posedge pclk);
    rd(core_pkg::A_ACC, {24'h0, v}, 1'b0);
    rd(core_pkg::A_STAT, (v == 8'h00) ? 32'h14 : 32'h10, 1'b0);
    rd(core_pkg::A_PC, 32'hd, 1'b0);
    cmp("port_latch", {24'h0, v}, {24'h0, port_latch});
    cmp("standby", 32'h1, {31'h0, standby});
    cmp("prescaler_clear", 32'h1, presc_pulses);
    cmp("watchdog_clear", 32'h1, wdc_pulses);
    summarize;
  end
endmodule : tb
`default_nettype wire
